// ===== tb/host_mcu_model.sv
// Host controller model driving the block's control pins.
// Assumes requests come from the bench just after a clock edge.
`timescale 1ns/1ps
module host_mcu_model
(
   input wire logic clk,
   input wire logic startReq,
   input wire logic wakeReq,
   input wire logic selectReq,
   output logic sequence_start = 1'b0,
   output logic wake_request_n = 1'b1,
   output logic chip_select_n = 1'b1
);
   // ****
   // Pin drive
   // ****
   // Never floats, even in low power
   always @(posedge clk)
   begin
      sequence_start <= startReq;
      wake_request_n <= !wakeReq;
      chip_select_n <= !selectReq;
   end
endmodule : host_mcu_model

// ===== tb/tb_top.sv
// Self-checking bench for the host control pin block.
// Assumes the host model in front of the pins and package constants.
`timescale 1ns/1ps
module tb_top
   import pin_ctrl_pkg::*;
;
   // ****
   // Signals
   // ****
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic startReq = 1'b0;
   logic wakeReq = 1'b0;
   logic selectReq = 1'b0;
   logic sequence_start, wake_request_n, chip_select_n;
   logic seqIsTx = 1'b0;
   logic ccaRequest = 1'b0;
   logic seqComplete = 1'b0;
   logic lowPowerRequest = 1'b0;
   logic [2:0] clockSelect = CLK_SEL_RESET;
   logic serialFloatEnable = 1'b1;
   logic serialDataOut = 1'b0;
   logic serialDataOutValid = 1'b0;
   logic irqRequest = 1'b0;
   logic irqPullupEnable = 1'b1;
   logic [GPIO_COUNT-1:0] gpioDirOut = '0;
   logic [GPIO_COUNT-1:0] gpioOutValue = '0;
   logic host_clock_out, serialOut, serialOutEn, irqOut, irqOutEn;
   logic irqPullup, analog_supply_enable, rxActive, txActive;
   logic serialSelected, transactionStart;
   logic [GPIO_COUNT-1:0] gpioOut, gpioOutEn;
   logic [4:0] modeState;
   int error_cnt = 0;
   int checks_done = 0;
   localparam logic [9:0] HALVES [1:7] =
      '{HALF_1, HALF_2, HALF_3, HALF_4, HALF_5, HALF_6, HALF_7};

   always #20 ref_clk = !ref_clk;

   host_mcu_model host (.clk(ref_clk), .startReq, .wakeReq,
      .selectReq, .sequence_start, .wake_request_n, .chip_select_n);

   host_pin_ctrl dut (.ref_clk, .sys_rst, .sequence_start,
      .wake_request_n, .chip_select_n, .seqIsTx, .ccaRequest,
      .seqComplete, .lowPowerRequest, .clockSelect,
      .serialFloatEnable, .serialDataOut, .serialDataOutValid,
      .irqRequest, .irqPullupEnable, .gpioDirOut, .gpioOutValue,
      .host_clock_out, .serialOut, .serialOutEn, .irqOut, .irqOutEn,
      .irqPullup, .gpioOut, .gpioOutEn, .analog_supply_enable,
      .rxActive, .txActive, .serialSelected, .transactionStart,
      .modeState);

   // ****
   // Tasks
   // ****
   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   task automatic chk(input string name, input logic [15:0] exp,
      input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Inputs change 1 ns after the edge, never on it
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step

   task automatic waitMode(input logic [4:0] m);
      int i;
      i = 0;
      while (modeState !== m && i < 50)
      begin
         step(1);
         i++;
      end
      chk("modeState", 16'(m), 16'(modeState));
      if (modeState !== m)
         complete_run();
   endtask : waitMode

   task automatic runSeq(input logic tx, input logic cca,
      input logic abort);
      seqIsTx = tx;
      ccaRequest = cca;
      startReq = 1'b1;
      waitMode(MODE_SEQ);
      step(1);
      chk("analog", 16'h0001, 16'(analog_supply_enable));
      chk("txActive", 16'(tx & !cca), 16'(txActive));
      chk("rxActive", 16'(!tx & !cca), 16'(rxActive));
      if (!abort)
      begin
         seqComplete = 1'b1;
         step(1);
         seqComplete = 1'b0;
         step(2);
         chk("doneMode", 16'(MODE_DONE), 16'(modeState));
         chk("analogDone", 16'h0000, 16'(analog_supply_enable));
      end
      startReq = 1'b0;
      waitMode(MODE_IDLE);
      step(1);
      chk("analog", 16'h0000, 16'(analog_supply_enable));
      chk("active", 16'h0000, 16'({rxActive, txActive}));
   endtask : runSeq

   task automatic nextRise(output int n);
      logic prev;
      n = 0;
      prev = 1'b1;
      while (!(prev === 1'b0 && host_clock_out === 1'b1) && n < 3000)
      begin
         prev = host_clock_out;
         step(1);
         n++;
      end
      // A stuck clock output ends the run at once
      if (n >= 3000)
      begin
         chk("clkRiseSeen", 16'h0001, 16'h0000);
         complete_run();
      end
   endtask : nextRise

   // First two periods skipped: select waits for a low point
   task automatic clkPer(input logic [2:0] s, input logic [9:0] half);
      int n;
      clockSelect = s;
      repeat (3) nextRise(n);
      chk("clkPeriod", {5'h00, half, 1'b0}, 16'(n));
   endtask : clkPer

   // ****
   // Sequence
   // ****
   initial
   begin
      int n;
      step(20);
      chk("resetMode", 16'(MODE_OFF), 16'(modeState));
      chk("gpioOutEn", 16'h0000, 16'(gpioOutEn));
      chk("irqPullup", 16'h0001, 16'(irqPullup));
      sys_rst = 1'b0;
      waitMode(MODE_IDLE);
      step(2);
      clkPer(CLK_SEL_RESET, HALF_6);
      runSeq(1'b0, 1'b0, 1'b0);
      runSeq(1'b1, 1'b0, 1'b1);
      runSeq(1'b0, 1'b1, 1'b0);
      lowPowerRequest = 1'b1;
      waitMode(MODE_LOWPWR);
      lowPowerRequest = 1'b0;
      chk("analog", 16'h0000, 16'(analog_supply_enable));
      wakeReq = 1'b1;
      waitMode(MODE_IDLE);
      wakeReq = 1'b0;
      step(6);
      chk("serialOutEn", 16'h0000, 16'(serialOutEn));
      serialFloatEnable = 1'b0;
      step(6);
      chk("drivenLow", 16'h0002, 16'({serialOutEn, serialOut}));
      selectReq = 1'b1;
      n = 0;
      repeat (10)
      begin
         step(1);
         n += int'(transactionStart === 1'b1);
      end
      chk("startPulses", 16'h0001, 16'(n));
      chk("selected", 16'h0001, 16'(serialSelected));
      serialDataOut = 1'b1;
      serialDataOutValid = 1'b1;
      step(2);
      chk("selOut", 16'h0003, 16'({serialOutEn, serialOut}));
      selectReq = 1'b0;
      step(6);
      chk("selected", 16'h0000, 16'(serialSelected));
      chk("drivenLow", 16'h0002, 16'({serialOutEn, serialOut}));
      irqRequest = 1'b1;
      step(3);
      chk("irqLow", 16'h0002, 16'({irqOutEn, irqOut}));
      irqRequest = 1'b0;
      irqPullupEnable = 1'b0;
      step(3);
      chk("irqIdle", 16'h0000, 16'({irqOutEn, irqPullup}));
      gpioDirOut = 7'h55;
      gpioOutValue = 7'h33;
      step(2);
      chk("gpio", 16'h2ab3, 16'({gpioOutEn, gpioOut}));
      for (int c = 1; c < 8; c++)
         clkPer(3'(c), HALVES[c]);
      complete_run();
   end
endmodule : tb_top

// ===== verilog/clock_out_div.sv
// Glitch-free divided clock output for the host.
// Assumes clk is the 16 MHz reference; select is synchronous.
`timescale 1ns/1ps
module clock_out_div
   import pin_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] sel,
   output logic clkOut
);
   logic [2:0] active;
   logic [2:0] next_active;
   logic [DIV_WIDTH-1:0] cnt;
   logic [DIV_WIDTH-1:0] next_cnt;
   logic divClk;
   logic next_divClk;
   logic [DIV_WIDTH-1:0] half;

   always_comb
   begin
      case (active)
         3'h1: half = HALF_1;
         3'h2: half = HALF_2;
         3'h3: half = HALF_3;
         3'h4: half = HALF_4;
         3'h5: half = HALF_5;
         3'h6: half = HALF_6;
         3'h7: half = HALF_7;
         default: half = HALF_1;
      endcase
   end

   // ***************************************************
   // Divider
   // ***************************************************
   // Bypass code 0 shows the reference as a toggling level at half rate
   // here; the true 16 MHz pass-through belongs in the clock tree.
   always_comb
   begin
      next_cnt = cnt + 10'h001;
      next_divClk = divClk;
      next_active = active;
      if (cnt >= half - 10'h001)
      begin
         next_cnt = '0;
         next_divClk = ~divClk;
         // Switch only when the old clock is about to fall low
         if (divClk && (sel != active)) // R15
         begin
            next_active = sel;
            next_divClk = 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt <= '0;
         divClk <= 1'b0;
         active <= CLK_SEL_RESET; // R5
      end
      else
      begin
         cnt <= next_cnt;
         divClk <= next_divClk;
         active <= next_active;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         clkOut <= 1'b0;
      else
         clkOut <= divClk;
   end

   AST_SWITCH_LOW: assert property (@(posedge clk) disable iff (rst)
      (active != $past(active)) |-> !divClk) // R15
      else $error("Clock select changed while output high");
endmodule : clock_out_div

// ===== verilog/host_pin_ctrl.sv
// Host control pin logic: sequencing, wake, clock out, serial output.
// Assumes ref_clk is the device reference; host pins are asynchronous.
//
// Notes on behaviour
// R1 - Rising sequence start launches receive or transmit chosen by setting.
// R2 - Host raises start after programming, holds it, lowers after done.
// R3 - Start held low forces Idle, ending receive or transmit.
// R4 - Low wake request moves Hibernate or Doze into Idle.
// R5 - Clock out selects eight divided rates, default about 32.8 kHz.
// R6 - Serial activity only while chip select low; ignored otherwise.
// R7 - Interrupt active low open drain, switchable pull-up, 6 us service.
// R8 - General I/O pins reset to inputs, no programmable pull-ups.
// R9 - Serial output floats when deselected unless float enable cleared.
// R10 - Host keeps driving all inputs during low power modes.
// R11 - Analog supply enabled only during assessment, receive or transmit.
// R12 - Reset held gives Off mode; release enters Idle with defaults.
// R13 - Transaction starts at chip select fall; header gives 6-bit address.
// R14 - Start and wake inputs synchronised before edge or level use.
// R15 - Clock output select switches only while output low.
`timescale 1ns/1ps
module host_pin_ctrl
   import pin_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic sequence_start,
   input wire logic wake_request_n,
   input wire logic chip_select_n,
   input wire logic seqIsTx,
   input wire logic ccaRequest,
   input wire logic seqComplete,
   input wire logic lowPowerRequest,
   input wire logic [2:0] clockSelect,
   input wire logic serialFloatEnable,
   input wire logic serialDataOut,
   input wire logic serialDataOutValid,
   input wire logic irqRequest,
   input wire logic irqPullupEnable,
   input wire logic [GPIO_COUNT-1:0] gpioDirOut,
   input wire logic [GPIO_COUNT-1:0] gpioOutValue,
   output logic host_clock_out,
   output logic serialOut,
   output logic serialOutEn,
   output logic irqOut,
   output logic irqOutEn,
   output logic irqPullup,
   output logic [GPIO_COUNT-1:0] gpioOut,
   output logic [GPIO_COUNT-1:0] gpioOutEn,
   output logic analog_supply_enable,
   output logic rxActive,
   output logic txActive,
   output logic serialSelected,
   output logic transactionStart,
   output logic [4:0] modeState
);
   // ***************************************************
   // Input synchronisers
   // ***************************************************
   logic [1:0] startSync;
   logic [1:0] wakeSync;
   logic [1:0] selSync;
   logic startPrev;
   logic selPrev;
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         startSync <= 2'h0;
         wakeSync <= 2'h3;
         selSync <= 2'h3;
         startPrev <= 1'b0;
         selPrev <= 1'b1;
      end
      else
      begin
         startSync <= {startSync[0], sequence_start}; // R14
         wakeSync <= {wakeSync[0], wake_request_n}; // R14
         selSync <= {selSync[0], chip_select_n};
         startPrev <= startSync[1];
         selPrev <= selSync[1];
      end
   end
   logic startRise;
   logic startLevel;
   logic wakeLevel;
   logic selLow;
   assign startRise = startSync[1] & ~startPrev; // R1
   assign startLevel = startSync[1];
   assign wakeLevel = ~wakeSync[1];
   assign selLow = ~selSync[1];

   // ***************************************************
   // Mode machine
   // ***************************************************
   mode_t mode;
   mode_t next_mode;
   logic isTx;
   logic next_isTx;
   logic isCca;
   logic next_isCca;
   always_comb
   begin
      next_mode = mode;
      next_isTx = isTx;
      next_isCca = isCca;
      case (mode)
         MODE_OFF: next_mode = MODE_IDLE; // R12
         MODE_IDLE:
         begin
            if (startRise) // R1
            begin
               next_mode = MODE_SEQ;
               next_isTx = seqIsTx;
               next_isCca = ccaRequest;
            end
            else if (lowPowerRequest)
               next_mode = MODE_LOWPWR;
         end
         MODE_SEQ:
         begin
            if (!startLevel) // R3
               next_mode = MODE_IDLE;
            else if (seqComplete)
               next_mode = MODE_DONE;
         end
         MODE_DONE:
            if (!startLevel) // R2
               next_mode = MODE_IDLE;
         MODE_LOWPWR:
            if (wakeLevel) // R4
               next_mode = MODE_IDLE;
         default: next_mode = MODE_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         mode <= MODE_OFF; // R12
         isTx <= 1'b0;
         isCca <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         isTx <= next_isTx;
         isCca <= next_isCca;
      end
   end

   // ***************************************************
   // Registered pin outputs
   // ***************************************************
   logic next_analog;
   logic next_serialOutEn;
   logic next_serialOut;
   always_comb
   begin
      next_analog = (next_mode == MODE_SEQ); // R11
      // Deselected: float, or drive low to save power
      if (selLow) // R6
      begin
         next_serialOutEn = serialDataOutValid;
         next_serialOut = serialDataOut;
      end
      else
      begin
         next_serialOutEn = ~serialFloatEnable; // R9
         next_serialOut = 1'b0;
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         analog_supply_enable <= 1'b0;
         serialOut <= 1'b0;
         serialOutEn <= 1'b0;
         irqOut <= 1'b0;
         irqOutEn <= 1'b0;
         irqPullup <= 1'b1;
         gpioOut <= '0;
         gpioOutEn <= '0; // R8
         rxActive <= 1'b0;
         txActive <= 1'b0;
         serialSelected <= 1'b0;
         transactionStart <= 1'b0;
         modeState <= 5'h01;
      end
      else
      begin
         analog_supply_enable <= next_analog;
         serialOut <= next_serialOut;
         serialOutEn <= next_serialOutEn;
         // Open drain: only ever drive low; one cycle well inside 6 us
         irqOut <= 1'b0; // R7
         irqOutEn <= irqRequest; // R7
         irqPullup <= irqPullupEnable; // R7
         gpioOut <= gpioOutValue;
         gpioOutEn <= gpioDirOut;
         rxActive <= (next_mode == MODE_SEQ) & ~next_isTx & ~next_isCca;
         txActive <= (next_mode == MODE_SEQ) & next_isTx & ~next_isCca;
         serialSelected <= selLow; // R6
         transactionStart <= selLow & selPrev; // R13
         modeState <= next_mode;
      end
   end

   clock_out_div u_clock_out_div (
      .clk(ref_clk),
      .rst(sys_rst),
      .sel(clockSelect),
      .clkOut(host_clock_out)
   );

   // ***************************************************
   // Checks
   // ***************************************************
   AST_START_LAUNCH: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mode == MODE_IDLE && startRise) |=> (mode == MODE_SEQ)) // R1
      else $error("Start edge did not launch a sequence");
   AST_START_LOW_IDLE: assert property (@(posedge ref_clk)
      disable iff (sys_rst)
      (mode == MODE_SEQ && !startLevel) |=> (mode == MODE_IDLE)) // R3
      else $error("Low start did not force idle");
   AST_WAKE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mode == MODE_LOWPWR && wakeLevel) |=> (mode == MODE_IDLE)) // R4
      else $error("Wake did not reach idle");
   AST_ANALOG: assert property (@(posedge ref_clk) disable iff (sys_rst)
      analog_supply_enable == (mode == MODE_SEQ)) // R11
      else $error("Analog supply out of step with sequence");
   AST_FLOAT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ($past(!selLow) && $past(serialFloatEnable)) |-> !serialOutEn) // R9
      else $error("Serial output driven while deselected");
   AST_DRIVE_LOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ($past(!selLow) && $past(!serialFloatEnable))
      |-> (serialOutEn && !serialOut)) // R9
      else $error("Serial output not driven low");
   AST_IRQ_OD: assert property (@(posedge ref_clk) disable iff (sys_rst)
      irqOutEn |-> !irqOut) // R7
      else $error("Interrupt drove high");
   AST_OFF_TO_IDLE: assert property (@(posedge ref_clk)
      $fell(sys_rst) |-> (mode == MODE_OFF) ##1 (mode == MODE_IDLE)) // R12
      else $error("Reset release did not enter idle");
   AST_TXN_START: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (selLow && selPrev) |=> transactionStart) // R13
      else $error("Missed chip select fall");
   COV_RX: cover property (@(posedge ref_clk) rxActive);
   COV_TX: cover property (@(posedge ref_clk) txActive);
   COV_WAKE: cover property (@(posedge ref_clk)
      mode == MODE_LOWPWR ##1 mode == MODE_IDLE);
endmodule : host_pin_ctrl

// ===== verilog/pin_ctrl_pkg.sv
// Constants for the host control pin block of the packet transceiver.
// Assumes a single reference clock; all other rates are enables.
package pin_ctrl_pkg;
   // ***************************************************
   // Clock output divider
   // ***************************************************
   localparam int REF_CLOCK_HZ = 16000000;
   localparam logic [2:0] CLK_SEL_RESET = 3'h6;
   localparam int DIV_WIDTH = 10;
   // Half periods in reference cycles per select code; code 0 is bypass
   localparam logic [9:0] HALF_1 = 10'h001;
   localparam logic [9:0] HALF_2 = 10'h002;
   localparam logic [9:0] HALF_3 = 10'h004;
   localparam logic [9:0] HALF_4 = 10'h008;
   localparam logic [9:0] HALF_5 = 10'h080;
   localparam logic [9:0] HALF_6 = 10'h0f4;
   localparam logic [9:0] HALF_7 = 10'h1e8;
   // ***************************************************
   // Interrupt service time
   // ***************************************************
   localparam int IRQ_SERVICE_NS = 6000;
   localparam int REF_PERIOD_NS = 1000000000 / REF_CLOCK_HZ;
   localparam int IRQ_SERVICE_CYC = IRQ_SERVICE_NS / REF_PERIOD_NS;
   // ***************************************************
   // Modes
   // ***************************************************
   typedef enum logic [4:0] {
      MODE_OFF = 5'h01,
      MODE_IDLE = 5'h02,
      MODE_SEQ = 5'h04,
      MODE_LOWPWR = 5'h08,
      MODE_DONE = 5'h10
   } mode_t;
   localparam int GPIO_COUNT = 7;
endpackage : pin_ctrl_pkg
